// ==== inc/acp_pkg.sv ====
// shared constants and types of the aux control and dual pointer block
package acp_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_AUX = 4'h0;
  localparam logic [3:0] REG_AUX_INC = 4'h1;
  localparam logic [3:0] REG_PTR_LO = 4'h2;
  localparam logic [3:0] REG_PTR_HI = 4'h3;
  localparam logic [3:0] REG_IRQ_STAT = 4'h4;
  localparam logic [3:0] REG_IRQ_EN = 4'h5;
  localparam logic [3:0] REG_IRQ_CLR = 4'h6;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] AUX_WMASK = 8'hF1;
  localparam logic [7:0] AUX_SEL_MASK = 8'h01;
  localparam int AUX_KBF = 7;
  localparam int AUX_BOD = 6;
  localparam int AUX_BOI = 5;
  localparam int AUX_LOW_POWER_PROG_BIT = 4;
  localparam int AUX_SOFT_RESET_BIT = 3;
  localparam int AUX_ZERO = 2;
  localparam int AUX_SEL = 0;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] PTR_ONE = 16'h0001;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int IRQ_W = 2;
  localparam int IRQ_KBD = 0;
  localparam int IRQ_PROG = 1;
  localparam logic [15:0] SIG_ADDR0 = 16'hFC30;
  localparam logic [15:0] SIG_ADDR1 = 16'hFC31;
  localparam logic [15:0] SIG_ADDR2 = 16'hFC60;
  localparam logic [15:0] CUST_FIRST = 16'hFCE0;
  localparam logic [15:0] CUST_LAST = 16'hFCFF;
  localparam int CUST_DEPTH = 32;
  localparam logic [15:0] CFG1_ADDR = 16'hFD00;
  localparam logic [15:0] CFG2_ADDR = 16'hFD01;
  localparam logic [7:0] UNPROG_BYTE = 8'hFF;
  localparam logic [7:0] PCMD_WRITE = 8'h01;
  localparam logic [7:0] PCMD_READ = 8'h02;
  localparam logic [4:0] PROG_HDR_LAST = 5'h17;
  localparam logic [4:0] PROG_BYTE_LAST = 5'h07;
  typedef enum logic [1:0] {
    ACP_IDLE = 2'b00,
    ACP_HDR = 2'b01,
    ACP_WDATA = 2'b10,
    ACP_RDATA = 2'b11
  } acp_prog_state_t;
endpackage

// ==== src/acp_info_mem.sv ====
// signature, customer code and config bytes with serial programming
`timescale 1ns/10ps
module acp_info_mem import acp_pkg::*; #(
  parameter logic [7:0] SIG0 = 8'h11, // arbitrary identity value
  parameter logic [7:0] SIG1 = 8'h22, // arbitrary identity value
  parameter logic [7:0] SIG2 = 8'h33 // arbitrary identity value
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic prog_mode,
  input wire logic prog_clk,
  input wire logic prog_dat,
  input wire logic [15:0] rd_addr,
  output logic [7:0] rd_data,
  output logic prog_dat_out,
  output logic prog_dat_oe_n,
  output logic prog_wr_done
);
  acp_prog_state_t state_reg;
  logic pclk_d_reg;
  logic [4:0] cnt_reg;
  logic [23:0] hdr_reg;
  logic [7:0] shift_reg;
  logic [7:0] cust_reg [CUST_DEPTH];
  logic [7:0] cfg1_reg;
  logic [7:0] cfg2_reg;
  logic rise;
  logic mem_wr;
  logic [15:0] hdr_addr;
  logic [7:0] wr_byte;
  logic [7:0] hdr_byte;

  function automatic logic [7:0] lookup(input logic [15:0] a);
    logic [7:0] v;
    v = UNPROG_BYTE;
    if (a == SIG_ADDR0) v = SIG0;
    else if (a == SIG_ADDR1) v = SIG1;
    else if (a == SIG_ADDR2) v = SIG2;
    else if (a >= CUST_FIRST && a <= CUST_LAST) v = cust_reg[a[4:0]];
    else if (a == CFG1_ADDR) v = cfg1_reg;
    else if (a == CFG2_ADDR) v = cfg2_reg;
    return v;
  endfunction

  assign rise = prog_clk & ~pclk_d_reg;
  assign hdr_addr = hdr_reg[15:0];
  assign wr_byte = {shift_reg[6:0], prog_dat};
  assign mem_wr = ce && rise && state_reg == ACP_WDATA &&
                  cnt_reg == PROG_BYTE_LAST;
  // always_comb also wakes on the storage read inside lookup
  always_comb begin
    rd_data = lookup(rd_addr);
  end

  always_comb begin
    hdr_byte = lookup({hdr_reg[14:0], prog_dat});
  end

  // serial command, address and data frame on two pins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ACP_IDLE;
      pclk_d_reg <= 1'b0;
      cnt_reg <= '0;
      hdr_reg <= '0;
      shift_reg <= '0;
      prog_dat_out <= 1'b0;
      prog_dat_oe_n <= 1'b1;
      prog_wr_done <= 1'b0;
    end else if (ce) begin
      pclk_d_reg <= prog_clk;
      prog_wr_done <= mem_wr;
      if (!prog_mode) begin
        state_reg <= ACP_IDLE;
        prog_dat_oe_n <= 1'b1;
        cnt_reg <= '0;
      end else if (state_reg == ACP_IDLE) begin
        state_reg <= ACP_HDR;
      end else if (rise) begin
        cnt_reg <= 5'(cnt_reg + 5'h01);
        case (state_reg)
          ACP_HDR: begin
            hdr_reg <= {hdr_reg[22:0], prog_dat};
            if (cnt_reg == PROG_HDR_LAST) begin
              cnt_reg <= '0;
              if (hdr_reg[22:15] == PCMD_WRITE) begin
                state_reg <= ACP_WDATA;
              end else if (hdr_reg[22:15] == PCMD_READ) begin
                state_reg <= ACP_RDATA;
                shift_reg <= hdr_byte;
                prog_dat_out <= hdr_byte[7];
                prog_dat_oe_n <= 1'b0;
              end
            end
          end
          ACP_WDATA: begin
            shift_reg <= wr_byte;
            if (cnt_reg == PROG_BYTE_LAST) begin
              cnt_reg <= '0;
              state_reg <= ACP_HDR;
            end
          end
          ACP_RDATA: begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            prog_dat_out <= shift_reg[6];
            if (cnt_reg == PROG_BYTE_LAST) begin
              cnt_reg <= '0;
              state_reg <= ACP_HDR;
              prog_dat_oe_n <= 1'b1;
            end
          end
          default: state_reg <= ACP_IDLE;
        endcase
      end
    end
  end

  // customer bytes share the programming path of the config bytes
  genvar i;
  generate
    for (i = 0; i < CUST_DEPTH; i++) begin : g_cust
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          cust_reg[i] <= UNPROG_BYTE;
        end else if (mem_wr && hdr_addr >= CUST_FIRST &&
                     hdr_addr <= CUST_LAST && hdr_addr[4:0] == 5'(i)) begin
          cust_reg[i] <= wr_byte;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg1_reg <= UNPROG_BYTE;
      cfg2_reg <= UNPROG_BYTE;
    end else if (mem_wr) begin
      if (hdr_addr == CFG1_ADDR) cfg1_reg <= wr_byte;
      if (hdr_addr == CFG2_ADDR) cfg2_reg <= wr_byte;
    end
  end
endmodule

// ==== src/acp_aux_ctrl.sv ====
// aux control register, dual data pointer and info space read path
`timescale 1ns/10ps
module acp_aux_ctrl import acp_pkg::*; #(
  parameter int KBD_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic wdt_reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic core_ptr_inc,
  input wire logic core_ptr_load,
  input wire logic [15:0] core_load_value,
  input wire logic [7:0] core_acc,
  input wire logic core_jump,
  input wire logic core_code_read,
  input wire logic core_move_read,
  output logic [15:0] core_jump_addr,
  output logic core_jump_valid,
  output logic [7:0] core_rdata,
  output logic core_rvalid,
  output logic core_reset,
  input wire logic [KBD_W-1:0] kbd_pin_n,
  input wire logic [KBD_W-1:0] kbd_pin_en,
  input wire logic prog_mode_pin,
  input wire logic prog_clk_pin,
  input wire logic prog_dat_in,
  output logic prog_dat_out,
  output logic prog_dat_oe_n,
  output logic brownout_off_bit,
  output logic brownout_irq_bit,
  output logic low_power_prog_bit,
  output logic irq
);
  localparam int SYNC_W = KBD_W + 3;

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [KBD_W-1:0] kbd_d_reg;
  logic [7:0] aux_reg;
  logic [7:0] aux_next;
  logic [15:0] ptr_reg [2];
  logic soft_rst_reg;
  logic int_rst;
  logic [IRQ_W-1:0] stat_reg;
  logic [IRQ_W-1:0] en_reg;
  logic [IRQ_W-1:0] events;
  logic [KBD_W-1:0] kbd_now;
  logic kbd_ev;
  logic sel;
  logic [15:0] sel_ptr;
  logic [15:0] acc_addr;
  logic [15:0] info_addr;
  logic [7:0] info_data;
  logic prog_wr_done;
  logic aux_wr;
  logic inc_wr;
  logic [7:0] rd_value;

  // two-stage synchronisers for all pin inputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // idle pin levels: keys high, mode and clock low, data high
      sync1_reg <= {{KBD_W{1'b1}}, 3'b001};
      sync2_reg <= {{KBD_W{1'b1}}, 3'b001};
    end else if (ce) begin
      sync1_reg <= {kbd_pin_n, prog_mode_pin, prog_clk_pin, prog_dat_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign kbd_now = sync2_reg[SYNC_W-1:3];
  assign int_rst = !reset_n || soft_rst_reg || wdt_reset;
  assign sel = aux_reg[AUX_SEL];
  assign sel_ptr = ptr_reg[sel];
  assign acc_addr = 16'(sel_ptr + {8'h00, core_acc});
  assign info_addr = core_move_read ? sel_ptr : acc_addr;
  assign aux_wr = ce && reg_wr && reg_addr == REG_AUX;
  assign inc_wr = ce && reg_wr && reg_addr == REG_AUX_INC;
  // falling edge on an enabled keyboard pin
  assign kbd_ev = |(kbd_pin_en & kbd_d_reg & ~kbd_now);
  assign events = {prog_wr_done, kbd_ev};

  acp_info_mem u_info (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .prog_mode(sync2_reg[2]),
    .prog_clk(sync2_reg[1]),
    .prog_dat(sync2_reg[0]),
    .rd_addr(info_addr),
    .rd_data(info_data),
    .prog_dat_out(prog_dat_out),
    .prog_dat_oe_n(prog_dat_oe_n),
    .prog_wr_done(prog_wr_done)
  );

  always_ff @(posedge clk) begin
    if (int_rst) begin
      // follow the pins so a key held over a soft or watchdog reset is no new edge
      kbd_d_reg <= kbd_now;
    end else if (ce) begin
      kbd_d_reg <= kbd_now;
    end
  end

  // soft reset request: one cycle, then common reset path
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= aux_wr && reg_wdata[AUX_SOFT_RESET_BIT] && !int_rst;
    end
  end

  // core restarts at the reset vector while this is high
  always_ff @(posedge clk) begin
    core_reset <= int_rst;
  end

  always_comb begin
    aux_next = aux_reg;
    if (aux_wr) begin
      aux_next = reg_wdata & AUX_WMASK;
    end else if (inc_wr) begin
      aux_next = aux_reg ^ AUX_SEL_MASK;
    end
    aux_next[AUX_KBF] = aux_next[AUX_KBF] | kbd_ev;
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      aux_reg <= AUX_RESET;
    end else if (ce) begin
      aux_reg <= aux_next;
    end
  end

  assign brownout_off_bit = aux_reg[AUX_BOD];
  assign brownout_irq_bit = aux_reg[AUX_BOI];
  assign low_power_prog_bit = aux_reg[AUX_LOW_POWER_PROG_BIT];

  // only the selected pointer sees loads, increments and byte writes
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ptr
      always_ff @(posedge clk) begin
        if (int_rst) begin
          ptr_reg[g] <= PTR_RESET;
        end else if (ce && sel == 1'(g)) begin
          if (core_ptr_load) begin
            ptr_reg[g] <= core_load_value;
          end else if (core_ptr_inc) begin
            ptr_reg[g] <= 16'(ptr_reg[g] + PTR_ONE);
          end else if (reg_wr && reg_addr == REG_PTR_LO) begin
            ptr_reg[g][7:0] <= reg_wdata;
          end else if (reg_wr && reg_addr == REG_PTR_HI) begin
            ptr_reg[g][15:8] <= reg_wdata;
          end
        end
      end
    end
  endgenerate

  // core-facing address and read results
  always_ff @(posedge clk) begin
    if (int_rst) begin
      core_jump_addr <= RESET_VECTOR;
      core_jump_valid <= 1'b0;
      core_rdata <= 8'h00;
      core_rvalid <= 1'b0;
    end else if (ce) begin
      core_jump_valid <= core_jump;
      core_rvalid <= core_code_read || core_move_read;
      if (core_jump) core_jump_addr <= acc_addr;
      if (core_code_read || core_move_read) begin
        core_rdata <= info_data;
      end
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge clk) begin
    if (int_rst) begin
      stat_reg <= '0;
      en_reg <= '0;
    end else if (ce) begin
      if (reg_wr && reg_addr == REG_IRQ_CLR) begin
        stat_reg <= (stat_reg & ~reg_wdata[IRQ_W-1:0]) | events;
      end else begin
        stat_reg <= stat_reg | events;
      end
      if (reg_wr && reg_addr == REG_IRQ_EN) en_reg <= reg_wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(stat_reg & en_reg);
    end
  end

  always_comb begin
    case (reg_addr)
      REG_AUX: rd_value = aux_reg & AUX_WMASK;
      REG_PTR_LO: rd_value = sel_ptr[7:0];
      REG_PTR_HI: rd_value = sel_ptr[15:8];
      REG_IRQ_STAT: rd_value = {{(8-IRQ_W){1'b0}}, stat_reg};
      REG_IRQ_EN: rd_value = {{(8-IRQ_W){1'b0}}, en_reg};
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_value : 8'h00;
    end
  end

  soft_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
    aux_wr && reg_wdata[AUX_SOFT_RESET_BIT] && !int_rst |=> soft_rst_reg ##1
    (core_reset && aux_reg == AUX_RESET && ptr_reg[0] == PTR_RESET))
    else $error("soft reset did not clear state");

  reset_path_a: assert property (@(posedge clk) disable iff (!reset_n)
    wdt_reset |=> core_reset && aux_reg == AUX_RESET && !aux_reg[AUX_SOFT_RESET_BIT])
    else $error("reset path did not clear aux register");

  bit_two_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    !aux_reg[AUX_ZERO] && !aux_reg[1])
    else $error("wired zero bit set");

  inc_toggle_a: assert property (@(posedge clk) disable iff (!reset_n)
    inc_wr && !int_rst && !kbd_ev && !soft_rst_reg |=>
    aux_reg == ($past(aux_reg) ^ AUX_SEL_MASK))
    else $error("increment changed more than select");

  ptr_inc_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && core_ptr_inc && !core_ptr_load && !int_rst && !inc_wr && !aux_wr
    |=> ptr_reg[$past(sel)] == 16'($past(sel_ptr) + PTR_ONE) &&
    ptr_reg[!$past(sel)] == $past(ptr_reg[!sel]))
    else $error("pointer increment wrong");

  ptr_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && core_ptr_load && !int_rst |=>
    ptr_reg[$past(sel)] == $past(core_load_value))
    else $error("pointer load wrong");

  jump_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && core_jump && !int_rst |=> core_jump_valid &&
    core_jump_addr == 16'($past(sel_ptr) + {8'h00, $past(core_acc)}))
    else $error("jump address not from selected pointer");

  ptr_byte_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && reg_rd && reg_addr == REG_PTR_HI && !int_rst |=>
    reg_rdata == $past(sel_ptr[15:8]))
    else $error("pointer high byte read wrong");

  kbd_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
    aux_reg[AUX_KBF] && !aux_wr && !int_rst |=> aux_reg[AUX_KBF])
    else $error("keyboard flag lost");

  kbd_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && kbd_ev && !int_rst |=> aux_reg[AUX_KBF] && stat_reg[IRQ_KBD])
    else $error("keyboard event not flagged");

  sig_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && core_code_read && !core_move_read && !int_rst &&
    acc_addr == SIG_ADDR0 |=> core_rvalid && core_rdata == u_info.SIG0)
    else $error("signature byte read wrong");
endmodule

// ==== verification/acp_core_model.sv ====
// processor core model issuing pointer based instructions
`timescale 1ns/10ps
module acp_core_model (
  input wire logic clk,
  output logic core_ptr_inc,
  output logic core_ptr_load,
  output logic [15:0] core_load_value,
  output logic [7:0] core_acc,
  output logic core_jump,
  output logic core_code_read,
  output logic core_move_read,
  input wire logic [15:0] core_jump_addr,
  input wire logic core_jump_valid,
  input wire logic [7:0] core_rdata,
  input wire logic core_rvalid
);
  initial begin
    core_ptr_inc = 1'b0;
    core_ptr_load = 1'b0;
    core_load_value = 16'h0000;
    core_acc = 8'h00;
    core_jump = 1'b0;
    core_code_read = 1'b0;
    core_move_read = 1'b0;
  end

  // kind: 0 inc, 1 load, 2 jump, 3 code read, 4 data move read
  task automatic op(input int kind, input logic [15:0] val,
    input logic [7:0] acc, output logic [15:0] got);
    @(posedge clk);
    core_ptr_inc <= (kind == 0);
    core_ptr_load <= (kind == 1);
    core_load_value <= val;
    core_acc <= acc;
    core_jump <= (kind == 2);
    core_code_read <= (kind == 3);
    core_move_read <= (kind == 4);
    @(posedge clk);
    {core_ptr_inc, core_ptr_load, core_jump} <= 3'h0;
    {core_code_read, core_move_read} <= 2'h0;
    // operands no longer held, so show their inverse
    core_load_value <= ~val;
    core_acc <= ~acc;
    @(posedge clk);
    got = 16'hXXXX;
    if (kind == 2 && core_jump_valid === 1'b1) begin
      got = core_jump_addr;
    end
    if (kind > 2 && core_rvalid === 1'b1) begin
      got = {8'h00, core_rdata};
    end
  endtask
endmodule

// ==== verification/test_acp_aux_ctrl.sv ====
// self-checking bench of the aux control and dual pointer block
`timescale 1ns/10ps
module test_acp_aux_ctrl import acp_pkg::*;;
  logic clk, reset_n, wdt_reset, reg_wr, reg_rd, irq, core_reset;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, core_acc, core_rdata;
  logic core_ptr_inc, core_ptr_load, core_jump, core_code_read;
  logic core_move_read, core_jump_valid, core_rvalid;
  logic [15:0] core_load_value, core_jump_addr, v;
  logic [7:0] kbd_pin_n, kbd_pin_en;
  logic brownout_off_bit, brownout_irq_bit, low_power_prog_bit;
  logic prog_mode, prog_clk, prog_dat, prog_dat_out, prog_dat_oe_n;
  logic [8:0] r;
  int num_errors, checks_done;

  acp_aux_ctrl acp_aux_ctrl_i (.clk, .reset_n, .ce(1'b1), .wdt_reset,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_ptr_inc,
    .core_ptr_load, .core_load_value, .core_acc, .core_jump,
    .core_code_read, .core_move_read, .core_jump_addr, .core_jump_valid,
    .core_rdata, .core_rvalid, .core_reset, .kbd_pin_n, .kbd_pin_en,
    .prog_mode_pin(prog_mode), .prog_clk_pin(prog_clk),
    .prog_dat_in(prog_dat), .prog_dat_out, .prog_dat_oe_n,
    .brownout_off_bit,
    .brownout_irq_bit, .low_power_prog_bit, .irq);

  acp_core_model acp_core_model_i (.clk, .core_ptr_inc, .core_ptr_load,
    .core_load_value, .core_acc, .core_jump, .core_code_read,
    .core_move_read, .core_jump_addr, .core_jump_valid, .core_rdata,
    .core_rvalid);

  always #5 clk = ~clk;

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] got,
    input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [3:0] a,
    input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(n, {8'h00, reg_rdata}, {8'h00, e});
  endtask

  // sel 1 waits on core_reset, sel 0 on irq
  task automatic wait_on(input bit sel, input logic lvl);
    int i;
    for (i = 0; i < 20 && (sel ? core_reset : irq) !== lvl; i++) begin
      @(posedge clk);
    end
    chk(sel ? "core_reset" : "irq", {15'h0, sel ? core_reset : irq},
      {15'h0, lvl});
    if (i == 20) begin
      results();
    end
  endtask

  // one programmer bit: low half, sample device bit, rising half
  task automatic pbit(input logic b, output logic s);
    @(posedge clk);
    prog_dat <= b;
    prog_clk <= 1'b0;
    repeat (4) @(posedge clk);
    s = prog_dat_out;
    prog_clk <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // 32-bit frame; rd[7:0] device bits, rd[8] enable before last rise
  task automatic pframe(input logic [7:0] cmd, input logic [15:0] a,
    input logic [7:0] d, output logic [8:0] rd);
    logic s;
    int k;
    logic [31:0] f;
    f = {cmd, a, d};
    rd = '0;
    for (k = 31; k >= 0; k--) begin
      if (k == 0) rd[8] = prog_dat_oe_n;
      pbit(f[k], s);
      if (k < 8) rd[k] = s;
    end
  endtask

  task automatic op(input int k, input logic [15:0] val,
    input logic [7:0] acc);
    acp_core_model_i.op(k, val, acc, v);
  endtask

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    wdt_reset = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    kbd_pin_n = 8'hFF;
    kbd_pin_en = 8'h01;
    prog_mode = 1'b0;
    prog_clk = 1'b0;
    prog_dat = 1'b1;
    num_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    wait_on(1, 1'b0);
    rchk("aux", REG_AUX, AUX_RESET);
    rchk("ptr_lo", REG_PTR_LO, 8'h00);
    rchk("unmapped", 4'hF, 8'h00);
    $display("test reset done");

    op(1, 16'h1234, 8'h00);
    wr(REG_AUX_INC, 8'h00);
    rchk("aux_sel", REG_AUX, 8'h01);
    op(1, 16'hABCD, 8'h00);
    rchk("p1_lo", REG_PTR_LO, 8'hCD);
    rchk("p1_hi", REG_PTR_HI, 8'hAB);
    wr(REG_AUX, 8'h00);
    rchk("p0_hi", REG_PTR_HI, 8'h12);
    op(0, 16'h0000, 8'h00);
    rchk("p0_lo", REG_PTR_LO, 8'h35);
    op(2, 16'h0000, 8'h10);
    chk("jump", v, 16'h1245);
    wr(REG_PTR_HI, 8'h56);
    op(2, 16'h0000, 8'hFF);
    chk("jump_byte", v, 16'h5734);
    op(1, 16'hFFFF, 8'h00);
    op(2, 16'h0000, 8'h02);
    chk("jump_wrap", v, 16'h0001);
    $display("test pointers done");

    wr(REG_AUX, 8'hF4);
    rchk("aux_mask", REG_AUX, 8'hF0);
    chk("aux_out", {13'h0, brownout_off_bit, brownout_irq_bit,
      low_power_prog_bit}, 16'h0007);
    wr(REG_AUX, 8'h00);
    op(1, SIG_ADDR0, 8'h00);
    op(3, 16'h0000, 8'h00);
    chk("sig0", v, 16'h0011);
    op(3, 16'h0000, 8'h01);
    chk("sig1", v, 16'h0022);
    op(1, SIG_ADDR2, 8'h00);
    op(3, 16'h0000, 8'h00);
    chk("sig2", v, 16'h0033);
    op(1, CUST_FIRST, 8'h00);
    op(3, 16'h0000, 8'h1F);
    chk("cust_last", v, {8'h00, UNPROG_BYTE});
    op(1, CFG1_ADDR, 8'h00);
    op(4, 16'h0000, 8'h00);
    chk("cfg1", v, {8'h00, UNPROG_BYTE});
    $display("test info space done");

    prog_mode <= 1'b1;
    repeat (4) @(posedge clk);
    pframe(PCMD_WRITE, CUST_FIRST, 8'h5A, r);
    pframe(PCMD_READ, CUST_FIRST, 8'h00, r);
    chk("prog_rd", {7'h0, r}, 16'h005A);
    prog_mode <= 1'b0;
    rchk("stat_prog", REG_IRQ_STAT, 8'h02);
    wr(REG_IRQ_CLR, 8'h02);
    op(1, CUST_FIRST, 8'h00);
    op(3, 16'h0000, 8'h00);
    chk("cust_first", v, 16'h005A);
    rchk("stat_pclr", REG_IRQ_STAT, 8'h00);
    $display("test programming done");

    wr(REG_IRQ_EN, 8'h01);
    kbd_pin_n <= 8'hFE;
    wait_on(0, 1'b1);
    rchk("stat", REG_IRQ_STAT, 8'h01);
    rchk("kbf", REG_AUX, 8'h80);
    wr(REG_IRQ_CLR, 8'h01);
    wr(REG_AUX, 8'h00);
    wait_on(0, 1'b0);
    rchk("stat_clr", REG_IRQ_STAT, 8'h00);
    wr(REG_IRQ_EN, 8'h00);
    kbd_pin_n <= 8'hFF;
    repeat (4) @(posedge clk);
    kbd_pin_n <= 8'hFE;
    repeat (8) @(posedge clk);
    chk("irq_masked", {15'h0, irq}, 16'h0000);
    rchk("stat_masked", REG_IRQ_STAT, 8'h01);
    wr(REG_IRQ_CLR, 8'h01);
    $display("test keyboard done");

    op(1, 16'h4321, 8'h00);
    wr(REG_AUX, 8'h08);
    wait_on(1, 1'b1);
    wait_on(1, 1'b0);
    rchk("aux_soft_reset_bit", REG_AUX, 8'h00);
    rchk("ptr_soft_reset_bit", REG_PTR_HI, 8'h00);
    op(1, 16'h4321, 8'h00);
    wdt_reset <= 1'b1;
    @(posedge clk);
    wdt_reset <= 1'b0;
    wait_on(1, 1'b1);
    wait_on(1, 1'b0);
    rchk("ptr_wdt", REG_PTR_HI, 8'h00);
    $display("test resets done");
    results();
  end
endmodule
